// File: design/csc_pkg.sv
// Constants, field layouts and carrier types of the config security control
package csc_pkg;
    localparam int SECTORS = 8;
    localparam int SECT_W = 3;
    localparam int KEY_W = 32;
    localparam int DIV_W = 16;

    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_CMD = 4'h1;
    localparam logic [3:0] OFF_RD_DIS = 4'h2;
    localparam logic [3:0] OFF_PG_DIS = 4'h3;
    localparam logic [3:0] OFF_ER_DIS = 4'h4;
    localparam logic [3:0] OFF_LOCK = 4'h5;
    localparam logic [3:0] OFF_KEY = 4'h6;
    localparam logic [3:0] OFF_THR_EN = 4'h7;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    localparam logic [3:0] OFF_SCAN_DIV = 4'h9;

    localparam int CTRL_MON = 0;
    localparam int CTRL_KEY = 1;
    localparam int CTRL_PING = 2;
    localparam int CTRL_USER_IMG = 3;
    localparam int CTRL_SCAN = 4;
    localparam int CTRL_LIVE = 5;
    localparam int CTRL_PORT_OFF = 6;
    localparam int CTRL_CRC = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    localparam int CMD_SCAN = 0;
    localparam int CMD_REFRESH = 1;
    localparam int CMD_CLR = 2;

    localparam int THR_NOKEY = 0;
    localparam int THR_LOCK = 1;
    localparam int THR_FACT = 2;
    localparam int THR_BADKEY = 3;
    localparam logic [3:0] THR_EN_RST = 4'hf;

    localparam logic [DIV_W-1:0] SCAN_DIV_RST = 16'h0008;
    localparam logic [KEY_W-1:0] KEY_RST = 32'h00000000;

    localparam logic [1:0] PORT_JTAG = 2'h0;
    localparam logic [1:0] PORT_SPI = 2'h1;
    localparam logic [1:0] PORT_I2C = 2'h2;
    localparam logic [1:0] PORT_BUS = 2'h3;

    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_PROG = 3'h1;
    localparam logic [2:0] OP_ERASE = 3'h2;
    localparam logic [2:0] OP_ID = 3'h3;
    localparam logic [2:0] OP_KEY = 3'h4;
    localparam logic [2:0] OP_FACT = 3'h5;
    localparam logic [2:0] OP_REFRESH = 3'h6;
    localparam logic [2:0] OP_DONE = 3'h7;

    typedef enum logic [2:0] {
        PH_MONITOR, PH_LOAD, PH_CRC, PH_USER, PH_ERASE, PH_FAIL
    } csc_phase_type;

    typedef struct packed {
        logic valid;
        logic [1:0] port;
        logic [2:0] op;
        logic [SECT_W-1:0] sector;
        logic [KEY_W-1:0] key;
    } csc_acc_type;

    typedef struct packed {
        logic valid;
        logic grant;
        logic threat;
    } csc_ans_type;

    typedef struct packed {
        logic load_req;
        logic image;
        logic crc_req;
        logic erase_req;
        logic repair_req;
        logic scan_tick;
    } csc_flash_type;
endpackage

// File: design/csc_config_security.sv
// Configuration sequencing, sector locks, tamper detection and upset scan
`timescale 1ns/1ps
module csc_config_security (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic por_ok_i,
    input wire logic bandgap_on_i,
    input wire logic core_low_bg_i,
    input wire logic core_low_lp_i,
    input wire logic latest_image_i,
    input wire logic load_done_i,
    input wire logic load_corrupt_i,
    input wire logic crc_done_i,
    input wire logic crc_ok_i,
    input wire logic erase_done_i,
    input wire logic scan_start_i,
    input wire logic scan_end_i,
    input wire logic upset_err_i,
    input wire logic reprogram_request_n_i,
    input wire logic tap_activate_i,
    input wire csc_pkg::csc_acc_type acc_i,
    output csc_pkg::csc_ans_type ans_o,
    output csc_pkg::csc_flash_type flash_o,
    output logic io_release_o,
    output logic int_reset_o,
    output logic threat_o,
    output logic [3:0] threat_type_o,
    output logic [1:0] threat_port_o,
    output logic upset_found_o,
    output logic tap_active_o
);
    typedef struct packed {
        csc_pkg::csc_phase_type phase;
        logic [7:0] ctrl;
        logic [csc_pkg::SECTORS-1:0] rd_dis;
        logic [csc_pkg::SECTORS-1:0] pg_dis;
        logic [csc_pkg::SECTORS-1:0] er_dis;
        logic hard_lock;
        logic [csc_pkg::KEY_W-1:0] key;
        logic [3:0] thr_en;
        logic [3:0] thr_sts;
        logic [1:0] thr_port;
        logic threat;
        logic key_ok;
        logic owned;
        logic [1:0] owner;
        logic prog_n_q;
        logic scan_busy;
        logic [csc_pkg::DIV_W-1:0] scan_div;
        logic [csc_pkg::DIV_W-1:0] div_cnt;
        logic upset_found;
        logic tap_active;
        logic [31:0] rdata;
        csc_pkg::csc_ans_type ans;
        csc_pkg::csc_flash_type fl;
        logic io_release;
        logic int_reset;
    } csc_state_type;

    csc_state_type r_reg;
    csc_state_type r_next;

    // Sector lock lookup for read, program and erase; every other operation kind is never locked
    function automatic logic sector_locked(
        input logic [2:0] op,
        input logic [csc_pkg::SECT_W-1:0] sec,
        input logic [csc_pkg::SECTORS-1:0] rd,
        input logic [csc_pkg::SECTORS-1:0] pg,
        input logic [csc_pkg::SECTORS-1:0] er
    );
        logic res;
        res = 1'b0;
        case (op)
            csc_pkg::OP_READ: res = rd[sec];
            csc_pkg::OP_PROG: res = pg[sec];
            csc_pkg::OP_ERASE: res = er[sec];
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    // Ping-pong wins over the user's pick
    function automatic logic boot_image(
        input logic [7:0] ctrl,
        input logic latest
    );
        return ctrl[csc_pkg::CTRL_PING] ? latest :
            ctrl[csc_pkg::CTRL_USER_IMG];
    endfunction

    always_comb begin
        csc_state_type n;
        logic ext;
        logic needs_key;
        logic [3:0] hit;
        logic refresh;
        logic scan_go;
        logic trip;
        logic thr_clr;
        logic load_end;
        n = r_reg;
        ext = 1'b0;
        needs_key = 1'b0;
        hit = 4'h0;
        refresh = 1'b0;
        scan_go = 1'b0;
        trip = 1'b0;
        thr_clr = 1'b0;
        load_end = 1'b0;
        // Pulses last one cycle
        n.ans = '0;
        n.fl.repair_req = 1'b0;
        n.fl.scan_tick = 1'b0;
        n.rdata = 32'h00000000;

        // Register writes
        if (wr_i) begin
            case (addr_i)
                csc_pkg::OFF_CTRL: n.ctrl = wdata_i[7:0];
                csc_pkg::OFF_CMD: begin
                    scan_go = wdata_i[csc_pkg::CMD_SCAN];
                    refresh = wdata_i[csc_pkg::CMD_REFRESH];
                    thr_clr = wdata_i[csc_pkg::CMD_CLR];
                end
                csc_pkg::OFF_RD_DIS: begin
                    if (!r_reg.hard_lock) begin
                        n.rd_dis = wdata_i[csc_pkg::SECTORS-1:0];
                    end
                end
                csc_pkg::OFF_PG_DIS: begin
                    if (!r_reg.hard_lock) begin
                        n.pg_dis = wdata_i[csc_pkg::SECTORS-1:0];
                    end
                end
                csc_pkg::OFF_ER_DIS: begin
                    if (!r_reg.hard_lock) begin
                        n.er_dis = wdata_i[csc_pkg::SECTORS-1:0];
                    end
                end
                // Hard lock can only be set; clearing needs a reset
                csc_pkg::OFF_LOCK: n.hard_lock = r_reg.hard_lock | wdata_i[0];
                csc_pkg::OFF_KEY: n.key = wdata_i;
                // Disabled threat types never latch
                csc_pkg::OFF_THR_EN: n.thr_en = wdata_i[3:0];
                csc_pkg::OFF_SCAN_DIV: n.scan_div = wdata_i[15:0];
                default: n.ctrl = r_reg.ctrl;
            endcase
        end

        // Register reads; the key itself never reads back
        if (rd_i) begin
            case (addr_i)
                csc_pkg::OFF_CTRL: n.rdata = {24'h000000, r_reg.ctrl};
                csc_pkg::OFF_RD_DIS: n.rdata = {24'h000000, r_reg.rd_dis};
                csc_pkg::OFF_PG_DIS: n.rdata = {24'h000000, r_reg.pg_dis};
                csc_pkg::OFF_ER_DIS: n.rdata = {24'h000000, r_reg.er_dis};
                csc_pkg::OFF_LOCK: n.rdata = {31'h00000000, r_reg.hard_lock};
                csc_pkg::OFF_THR_EN: n.rdata = {28'h0000000, r_reg.thr_en};
                // Status bit 3 is spare
                csc_pkg::OFF_STATUS: n.rdata = {12'h000, r_reg.fl.image,
                    r_reg.owner, r_reg.owned, r_reg.hard_lock,
                    r_reg.upset_found, r_reg.scan_busy, r_reg.io_release,
                    r_reg.key_ok, |r_reg.thr_sts, r_reg.thr_port,
                    r_reg.thr_sts, 1'b0, r_reg.phase};
                csc_pkg::OFF_SCAN_DIV: n.rdata = {16'h0000, r_reg.scan_div};
                default: n.rdata = 32'h00000000;
            endcase
        end

        // Access requests from configuration ports and the internal bus
        if (acc_i.valid) begin
            ext = acc_i.port != csc_pkg::PORT_BUS;
            n.ans.valid = 1'b1;
            // Bus masters never need the key
            needs_key = ext && r_reg.ctrl[csc_pkg::CTRL_KEY] && !r_reg.key_ok;
            if (ext && (r_reg.ctrl[csc_pkg::CTRL_PORT_OFF] ||
                (r_reg.owned && r_reg.owner != acc_i.port))) begin
                n.ans.grant = 1'b0;
            end else begin
                case (acc_i.op)
                    csc_pkg::OP_ID: n.ans.grant = 1'b1;
                    csc_pkg::OP_DONE: begin
                        n.ans.grant = 1'b1;
                        n.owned = 1'b0;
                    end
                    csc_pkg::OP_KEY: begin
                        if (acc_i.key == r_reg.key) begin
                            n.key_ok = 1'b1;
                            n.ans.grant = 1'b1;
                        end else begin
                            // Wrong key drops a good one
                            n.key_ok = 1'b0;
                            hit[csc_pkg::THR_BADKEY] = 1'b1;
                        end
                    end
                    // Never granted, from any port
                    csc_pkg::OP_FACT: hit[csc_pkg::THR_FACT] = 1'b1;
                    default: begin
                        if (needs_key) begin
                            hit[csc_pkg::THR_NOKEY] = 1'b1;
                        end else if (sector_locked(acc_i.op, acc_i.sector,
                            r_reg.rd_dis, r_reg.pg_dis, r_reg.er_dis)) begin
                            hit[csc_pkg::THR_LOCK] = 1'b1;
                        end else begin
                            n.ans.grant = 1'b1;
                            refresh = refresh ||
                                acc_i.op == csc_pkg::OP_REFRESH;
                        end
                    end
                endcase
                // First external attempt claims the port
                if (ext && acc_i.op != csc_pkg::OP_DONE) begin
                    n.owned = 1'b1;
                    n.owner = acc_i.port;
                end
            end
            // Only external ports count as tamper sources
            hit = hit & {4{ext}} & r_reg.thr_en;
            n.ans.threat = |hit;
        end

        // New threats win over a clear in the same cycle
        n.thr_sts = (thr_clr ? 4'h0 : r_reg.thr_sts) | hit;
        if (|hit) begin
            n.thr_port = acc_i.port;
        end

        // Test port activation ignores port ownership
        if (tap_activate_i) begin
            n.tap_active = 1'b1;
        end

        // Falling edge of the reprogram pin acts as refresh
        n.prog_n_q = reprogram_request_n_i;
        if (r_reg.prog_n_q && !reprogram_request_n_i) begin
            refresh = 1'b1;
        end

        // Coarse monitor takes over while the bandgap is off
        trip = r_reg.ctrl[csc_pkg::CTRL_MON] &&
            (bandgap_on_i ? core_low_bg_i : core_low_lp_i);

        case (r_reg.phase)
            csc_pkg::PH_MONITOR: begin
                if (por_ok_i) begin
                    n.phase = csc_pkg::PH_LOAD;
                    n.fl.image = boot_image(r_reg.ctrl,
                        latest_image_i);
                end
            end
            csc_pkg::PH_LOAD: begin
                if (load_done_i) begin
                    if (load_corrupt_i) begin
                        if (!r_reg.fl.image) begin
                            n.fl.image = 1'b1;
                        end else begin
                            // No image left to fall back on
                            n.phase = csc_pkg::PH_FAIL;
                        end
                    end else if (r_reg.ctrl[csc_pkg::CTRL_CRC]) begin
                        n.phase = csc_pkg::PH_CRC;
                    end else begin
                        n.phase = csc_pkg::PH_USER;
                        load_end = 1'b1;
                    end
                end
            end
            csc_pkg::PH_CRC: begin
                if (crc_done_i) begin
                    n.phase = crc_ok_i ? csc_pkg::PH_USER :
                        csc_pkg::PH_FAIL;
                    load_end = crc_ok_i;
                end
            end
            csc_pkg::PH_USER: begin
                if (trip) begin
                    n.phase = csc_pkg::PH_MONITOR;
                end else if (refresh) begin
                    if (r_reg.ctrl[csc_pkg::CTRL_LIVE]) begin
                        n.fl.repair_req = 1'b1;
                    end else begin
                        n.phase = csc_pkg::PH_ERASE;
                    end
                end
            end
            csc_pkg::PH_ERASE: begin
                if (erase_done_i) begin
                    n.phase = csc_pkg::PH_LOAD;
                    // Soft reset picks the image afresh
                    n.fl.image = boot_image(r_reg.ctrl,
                        latest_image_i);
                end
            end
            csc_pkg::PH_FAIL: begin
                // A failed load waits for a soft reset
                if (refresh) begin
                    n.phase = csc_pkg::PH_ERASE;
                end
            end
            default: n.phase = csc_pkg::PH_MONITOR;
        endcase

        // Upset scanner; disabling it also stops the divider
        // Tick period is scan_div plus one cycles
        if (!r_reg.ctrl[csc_pkg::CTRL_SCAN] ||
            n.phase != csc_pkg::PH_USER) begin
            n.scan_busy = 1'b0;
            n.div_cnt = 16'h0000;
        end else if (!r_reg.scan_busy) begin
            if (load_end || scan_go || scan_start_i) begin
                n.scan_busy = 1'b1;
                n.upset_found = 1'b0;
                n.div_cnt = 16'h0000;
            end
        end else if (scan_end_i) begin
            n.scan_busy = 1'b0;
            n.upset_found = upset_err_i;
        end else if (r_reg.div_cnt >= r_reg.scan_div) begin
            n.div_cnt = 16'h0000;
            n.fl.scan_tick = 1'b1;
        end else begin
            n.div_cnt = 16'(r_reg.div_cnt + 16'h0001);
        end

        // Port ownership ends with each new configuration load
        if (n.phase == csc_pkg::PH_MONITOR ||
            n.phase == csc_pkg::PH_ERASE) begin
            n.owned = r_reg.owned && r_reg.phase == n.phase;
        end

        // Registered so every pin comes from a flop
        n.threat = |n.thr_sts;
        n.fl.load_req = n.phase == csc_pkg::PH_LOAD;
        n.fl.crc_req = n.phase == csc_pkg::PH_CRC;
        n.fl.erase_req = n.phase == csc_pkg::PH_ERASE;
        n.io_release = n.phase == csc_pkg::PH_USER;
        n.int_reset = n.phase != csc_pkg::PH_USER;
        r_next = n;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r_reg <= '0;
            r_reg.phase <= csc_pkg::PH_MONITOR;
            r_reg.ctrl <= csc_pkg::CTRL_RST;
            r_reg.key <= csc_pkg::KEY_RST;
            r_reg.thr_en <= csc_pkg::THR_EN_RST;
            r_reg.scan_div <= csc_pkg::SCAN_DIV_RST;
            // Pin idles high: no false edge after reset
            r_reg.prog_n_q <= 1'b1;
            r_reg.int_reset <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rdata_o = r_reg.rdata;
    assign ans_o = r_reg.ans;
    assign flash_o = r_reg.fl;
    assign io_release_o = r_reg.io_release;
    assign int_reset_o = r_reg.int_reset;
    assign threat_o = r_reg.threat;
    assign threat_type_o = r_reg.thr_sts;
    assign threat_port_o = r_reg.thr_port;
    assign upset_found_o = r_reg.upset_found;
    assign tap_active_o = r_reg.tap_active;
endmodule // csc_config_security

// File: testbench/csc_config_security_monitor.sv
// Port-level checker of the config security control
`timescale 1ns/1ps
module csc_config_security_monitor (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic por_ok_i,
    input wire logic tap_activate_i,
    input wire csc_pkg::csc_acc_type acc_i,
    input wire csc_pkg::csc_ans_type ans_o,
    input wire csc_pkg::csc_flash_type flash_o,
    input wire logic io_release_o,
    input wire logic int_reset_o,
    input wire logic threat_o,
    input wire logic [3:0] threat_type_o,
    input wire logic [1:0] threat_port_o,
    input wire logic tap_active_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);
    a_io_user: assert property (io_release_o != int_reset_o)
        else $error("io release and internal reset agree");
    a_load_io: assert property (flash_o.load_req |-> !io_release_o)
        else $error("io released while loading");
    a_load_start: assert property ($rose(flash_o.load_req) |->
        $past(por_ok_i)) else $error("load began without supplies");
    a_ans_follows: assert property (acc_i.valid |=> ans_o.valid)
        else $error("access not answered");
    a_ans_cause: assert property (ans_o.valid |-> $past(acc_i.valid))
        else $error("answer without access");
    a_fact_refused: assert property (acc_i.valid &&
        acc_i.op == csc_pkg::OP_FACT |=> !ans_o.grant)
        else $error("factory mode granted");
    a_thr_port: assert property (ans_o.threat |-> threat_o &&
        threat_port_o == $past(acc_i.port))
        else $error("threat source port wrong");
    a_thr_flag: assert property (threat_o == (|threat_type_o))
        else $error("threat flag and type bits differ");
    a_id_free: assert property (acc_i.valid &&
        acc_i.op == csc_pkg::OP_ID && acc_i.port == csc_pkg::PORT_BUS
        |=> ans_o.grant) else $error("id read refused");
    a_tap_sticky: assert property (tap_activate_i |=>
        tap_active_o [*4]) else $error("test port not activated");
    a_repair_pulse: assert property (flash_o.repair_req |->
        io_release_o ##1 !flash_o.repair_req)
        else $error("repair disturbed user mode");
    a_erase_reset: assert property (flash_o.erase_req |->
        int_reset_o && !io_release_o) else $error("erase without reset");
    a_tick_pulse: assert property (flash_o.scan_tick |=>
        !flash_o.scan_tick) else $error("scan tick too long");
endmodule // csc_config_security_monitor

bind csc_config_security csc_config_security_monitor csc_mon_i (.*);

// File: testbench/csc_host_model.sv
// Behavioural configuration host driving the access port
`timescale 1ns/1ps
module csc_host_model (
    input wire logic clk_sys_i,
    input wire csc_pkg::csc_ans_type ans_i,
    output csc_pkg::csc_acc_type acc_o
);
    csc_pkg::csc_ans_type got;
    csc_pkg::csc_acc_type idle;
    initial acc_o = '0;
    // Caller keeps one port for a whole cycle
    task automatic send(input logic [1:0] p, input logic [2:0] op,
            input logic [2:0] s, input logic [31:0] k);
        @(posedge clk_sys_i);
        acc_o <= '{1'b1, p, op, s, k}; // Key shift carries candidate
        @(posedge clk_sys_i);
        idle = ~acc_o;
        idle.valid = 1'b0;
        acc_o <= idle; // Released lines toggle, never hold stale data
        @(negedge clk_sys_i);
        got = ans_i;
    endtask
endmodule // csc_host_model

// File: testbench/config_security_control_tb_top.sv
// Self-checking bench with a reference model of locks and threats
`timescale 1ns/1ps
module config_security_control_tb_top;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h00000000, d, key;
    logic por_ok_i = 1'b0, bandgap_on_i = 1'b1, core_low_bg_i = 1'b0;
    logic core_low_lp_i = 1'b0, latest_image_i = 1'b0, load_done_i = 1'b0;
    logic load_corrupt_i = 1'b0, crc_done_i = 1'b0, crc_ok_i = 1'b0;
    logic erase_done_i = 1'b0, scan_start_i = 1'b0, scan_end_i = 1'b0;
    logic upset_err_i = 1'b0, reprogram_request_n_i = 1'b1;
    logic tap_activate_i = 1'b0, io_release_o, int_reset_o, threat_o;
    logic upset_found_o, tap_active_o;
    logic [31:0] rdata_o;
    logic [3:0] threat_type_o;
    logic [1:0] threat_port_o;
    csc_pkg::csc_acc_type acc_i;
    csc_pkg::csc_ans_type ans_o;
    csc_pkg::csc_flash_type flash_o;
    int bad_count = 0, n_checks = 0, seed = 34212, i;
    int rdm, pgm, erm, thr = 0, keyok = 0, ctrl = 0, owner = -1;
    logic [3:0] ra[5] = '{4'h0, 4'h7, 4'h9, 4'h6, 4'hf};
    logic [31:0] rv[5] = '{32'h0, 32'hf, 32'h8, 32'h0, 32'h0};

    always #2.5 clk_sys_i = ~clk_sys_i;
    csc_config_security csc_config_security_i (.*);
    csc_host_model csc_host_model_i (.clk_sys_i(clk_sys_i), .ans_i(ans_o),
        .acc_o(acc_i));

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task end_of_test;
        if (bad_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata_o;
    endtask
    task setc(input int b, input int v);
        ctrl[b] = v;
        wr(csc_pkg::OFF_CTRL, 32'(ctrl));
    endtask
    task pls(input int w);
        @(posedge clk_sys_i);
        case (w)
            0: load_done_i <= 1'b1;
            1: erase_done_i <= 1'b1;
            2: crc_done_i <= 1'b1;
            3: scan_end_i <= 1'b1;
            4: tap_activate_i <= 1'b1;
            default: scan_start_i <= 1'b1;
        endcase
        @(posedge clk_sys_i);
        {load_done_i, erase_done_i, crc_done_i} <= 3'h0;
        {scan_end_i, tap_activate_i, scan_start_i} <= 3'h0;
        @(negedge clk_sys_i);
    endtask
    // Reference answer of the access port, worked out before sending
    task acc(input logic [1:0] p, input logic [2:0] op, input logic [2:0] s,
            input logic [31:0] k);
        int g, t, m;
        m = op == csc_pkg::OP_READ ? rdm : op == csc_pkg::OP_PROG ? pgm : erm;
        g = 1;
        t = -1;
        if (p != csc_pkg::PORT_BUS && !ctrl[6] && owner < 0) owner = p;
        if (p != csc_pkg::PORT_BUS && (ctrl[6] || owner != p)) g = 0;
        else if (op == csc_pkg::OP_FACT) begin
            g = 0;
            t = csc_pkg::THR_FACT;
        end else if (op == csc_pkg::OP_KEY) begin
            keyok = (k == key);
            g = keyok;
            if (!keyok) t = csc_pkg::THR_BADKEY;
        end else if (op <= csc_pkg::OP_ERASE) begin
            if (ctrl[1] && !keyok) begin
                g = 0;
                t = csc_pkg::THR_NOKEY;
            end else if (m[s]) begin
                g = 0;
                if (p != csc_pkg::PORT_BUS) t = csc_pkg::THR_LOCK;
            end
        end
        csc_host_model_i.send(p, op, s, k);
        if (op == csc_pkg::OP_DONE) owner = -1;
        if (op == csc_pkg::OP_DONE) return;
        if (t >= 0) thr[t] = 1;
        chk("grant", 32'(csc_host_model_i.got.grant), g);
        chk("threat", 32'(csc_host_model_i.got.threat), t >= 0);
        chk("type", 32'(threat_type_o), thr);
        if (t >= 0) chk("port", 32'(threat_port_o), 32'(p));
    endtask

    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(negedge clk_sys_i);
        chk("int_reset", int_reset_o, 1);
        @(posedge clk_sys_i);
        por_ok_i <= 1'b1;
        for (i = 0; i < 20 && flash_o.load_req !== 1'b1; i++) @(negedge clk_sys_i);
        chk("load_req", flash_o.load_req, 1);
        @(posedge clk_sys_i);
        load_corrupt_i <= 1'b1;
        pls(0);
        chk("golden", {flash_o.image, flash_o.load_req}, 2'h3);
        @(posedge clk_sys_i);
        load_corrupt_i <= 1'b0;
        pls(0);
        for (i = 0; i < 20 && io_release_o !== 1'b1; i++) @(negedge clk_sys_i);
        chk("user", {io_release_o, int_reset_o}, 2'h2);
        for (i = 0; i < 5; i++) begin
            rd(ra[i]);
            chk("reg", d, rv[i]);
        end
        rdm = ($random(seed) & 8'hff) | 1;
        pgm = $random(seed) & 8'hff;
        erm = $random(seed) & 8'hff;
        wr(csc_pkg::OFF_RD_DIS, 32'(rdm));
        wr(csc_pkg::OFF_PG_DIS, 32'(pgm));
        wr(csc_pkg::OFF_ER_DIS, 32'(erm));
        rd(csc_pkg::OFF_PG_DIS);
        chk("soft lock", d, 32'(pgm));
        acc(csc_pkg::PORT_BUS, csc_pkg::OP_READ, 3'h0, 32'h0);
        acc(csc_pkg::PORT_BUS, csc_pkg::OP_ID, 3'h0, 32'h0);
        for (i = 0; i < 24; i++)
            acc(csc_pkg::PORT_SPI, 3'($random(seed) & 3), 3'($random(seed)),
                32'h0);
        acc(csc_pkg::PORT_SPI, csc_pkg::OP_FACT, 3'h0, 32'h0);
        acc(csc_pkg::PORT_JTAG, csc_pkg::OP_READ, 3'h1, 32'h0);
        acc(csc_pkg::PORT_SPI, csc_pkg::OP_DONE, 3'h0, 32'h0);
        wr(csc_pkg::OFF_LOCK, 32'h1);
        wr(csc_pkg::OFF_RD_DIS, 32'(~rdm));
        rd(csc_pkg::OFF_RD_DIS);
        chk("hard lock", d, 32'(rdm));
        key = $random(seed);
        wr(csc_pkg::OFF_KEY, key);
        setc(1, 1);
        acc(csc_pkg::PORT_JTAG, csc_pkg::OP_PROG, 3'h2, 32'h0);
        acc(csc_pkg::PORT_JTAG, csc_pkg::OP_KEY, 3'h0, key ^ 32'h1);
        acc(csc_pkg::PORT_JTAG, csc_pkg::OP_KEY, 3'h0, key);
        acc(csc_pkg::PORT_JTAG, csc_pkg::OP_ERASE, 3'($random(seed)), 32'h0);
        wr(csc_pkg::OFF_CMD, 32'h4);
        thr = 0;
        @(negedge clk_sys_i);
        chk("cleared", {threat_o, threat_type_o}, 5'h00);
        setc(6, 1);
        acc(csc_pkg::PORT_JTAG, csc_pkg::OP_ID, 3'h0, 32'h0);
        setc(6, 0);
        setc(4, 1);
        for (int w = 0; w < 2; w++) begin
            if (w == 0) wr(csc_pkg::OFF_CMD, 32'h1);
            else pls(5);
            for (i = 0; i < 30 && flash_o.scan_tick !== 1'b1; i++) @(negedge clk_sys_i);
            chk("scan tick", flash_o.scan_tick, 1);
            @(posedge clk_sys_i);
            upset_err_i <= w == 0;
            pls(3);
            chk("upset", upset_found_o, w == 0);
        end
        pls(4);
        chk("tap", tap_active_o, 1);
        setc(5, 1);
        reprogram_request_n_i <= 1'b0;
        for (i = 0; i < 10 && flash_o.repair_req !== 1'b1; i++) @(negedge clk_sys_i);
        chk("repair", {flash_o.repair_req, io_release_o}, 2'h3);
        @(posedge clk_sys_i);
        reprogram_request_n_i <= 1'b1;
        setc(5, 0);
        setc(3, 1);
        setc(2, 1);
        setc(7, 1);
        reprogram_request_n_i <= 1'b0;
        for (i = 0; i < 10 && flash_o.erase_req !== 1'b1; i++) @(negedge clk_sys_i);
        chk("erase", {flash_o.erase_req, int_reset_o}, 2'h3);
        @(posedge clk_sys_i);
        reprogram_request_n_i <= 1'b1;
        crc_ok_i <= 1'b1;
        pls(1);
        for (i = 0; i < 10 && flash_o.load_req !== 1'b1; i++) @(negedge clk_sys_i);
        chk("ping image", flash_o.image, 0);
        pls(0);
        for (i = 0; i < 10 && flash_o.crc_req !== 1'b1; i++) @(negedge clk_sys_i);
        chk("crc", {flash_o.crc_req, io_release_o}, 2'h2);
        pls(2);
        for (i = 0; i < 10 && io_release_o !== 1'b1; i++) @(negedge clk_sys_i);
        chk("crc pass", io_release_o, 1);
        setc(0, 1);
        bandgap_on_i <= 1'b0;
        core_low_bg_i <= 1'b1;
        repeat (5) @(negedge clk_sys_i);
        chk("coarse only", io_release_o, 1);
        @(posedge clk_sys_i);
        core_low_lp_i <= 1'b1;
        for (i = 0; i < 10 && io_release_o !== 1'b0; i++) @(negedge clk_sys_i);
        chk("trip", {io_release_o, int_reset_o}, 2'h1);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        end_of_test();
    end
endmodule // config_security_control_tb_top
